// ---- erd_pkg.sv ----
package erd_pkg;

   localparam logic [3:0] LAST_BIT      = 4'h9;
   localparam logic       RD_NEG        = 1'b0;
   localparam logic       RD_POS        = 1'b1;
   localparam logic       RD_RESET      = 1'b0;
   localparam logic [7:0] K_COMMA       = 8'hbc;
   localparam logic [7:0] K_SECOND      = 8'h7c;
   localparam logic [5:0] K28_6B_NEG    = 6'h0f;
   localparam logic [5:0] SB6_POS_SPEC  = 6'h07;
   localparam logic [5:0] SB6_NEG_SPEC  = 6'h38;
   localparam logic [3:0] SB4_POS_SPEC  = 4'h3;
   localparam logic [3:0] SB4_NEG_SPEC  = 4'hc;
   localparam logic [2:0] HGF_SEVEN     = 3'h7;
   localparam logic [3:0] ALT7_NEG      = 4'h7;

   // Six-bit sub-block, negative column
   function automatic logic [5:0] sb6_neg(input logic [4:0] x);
      logic [5:0] t [32];
      t = '{6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
            6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
            6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
            6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
      return t[x];
   endfunction : sb6_neg

   // Four-bit sub-block, negative column, primary seven
   function automatic logic [3:0] sb4_neg(input logic [2:0] y);
      logic [3:0] t [8];
      t = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
      return t[y];
   endfunction : sb4_neg

   // Ending disparity of a six-bit sub-block
   function automatic logic sub_rd6(input logic [5:0] v, input logic rd);
      if (v == SB6_POS_SPEC) return RD_POS;     // RQ13
      if (v == SB6_NEG_SPEC) return RD_NEG;     // RQ14
      if ($countones(v) > 3) return RD_POS;     // RQ13
      if ($countones(v) < 3) return RD_NEG;     // RQ14
      return rd;     // RQ15
   endfunction : sub_rd6

   // Ending disparity of a four-bit sub-block
   function automatic logic sub_rd4(input logic [3:0] v, input logic rd);
      if (v == SB4_POS_SPEC) return RD_POS;
      if (v == SB4_NEG_SPEC) return RD_NEG;
      if ($countones(v) > 2) return RD_POS;
      if ($countones(v) < 2) return RD_NEG;
      return rd;
   endfunction : sub_rd4

   // Ending disparity of a whole character
   function automatic logic char_rd(input logic [9:0] c, input logic rd);
      return sub_rd4(c[3:0], sub_rd6(c[9:4], rd));     // RQ12
   endfunction : char_rd

   // Byte plus kind to abcdei fghj, a in bit 9
   function automatic logic [9:0] encode(input logic [7:0] b, input logic k,
                                         input logic rd);
      logic [5:0] s6;
      logic [3:0] s4;
      logic       rd6;
      s6 = k ? K28_6B_NEG : sb6_neg(b[4:0]);     // RQ5
      if (rd == RD_POS && ($countones(s6) != 3 || s6 == SB6_NEG_SPEC))     // RQ16 RQ17
         s6 = ~s6;
      rd6 = sub_rd6(s6, rd);
      if (!k && b[7:5] == HGF_SEVEN &&
          ((rd6 == RD_POS && s6[1:0] == 2'h0) ||
           (rd6 == RD_NEG && s6[1:0] == 2'h3))) begin
         s4 = (rd6 == RD_POS) ? ~ALT7_NEG : ALT7_NEG;     // RQ18
      end else begin
         s4 = sb4_neg(b[7:5]);
         if (rd6 == RD_POS && ($countones(s4) != 2 || s4 == SB4_NEG_SPEC))
            s4 = ~s4;
      end
      return {s6, s4};
   endfunction : encode

endpackage : erd_pkg

// ---- erd_enc.sv ----
`timescale 1ns/1ps
module erd_enc (
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       load,
   input  wire logic [7:0] byte_in,
   input  wire logic       kind,
   input  wire logic       kind_given,
   output logic      [9:0] code,
   output logic            rd
);
   logic kind_eff;
   logic rd_r;

   // Missing kind means data
   assign kind_eff = kind_given & kind;     // RQ4
   assign code     = erd_pkg::encode(byte_in, kind_eff, rd_r);     // RQ8
   assign rd       = rd_r;

   // Disparity after each character sent
   always_ff @(posedge clock) begin
      if (!rst_n)
         rd_r <= erd_pkg::RD_RESET;
      else if (load)
         rd_r <= erd_pkg::char_rd(code, rd_r);     // RQ9
   end
endmodule : erd_enc

// ---- erd_dec.sv ----
`timescale 1ns/1ps
module erd_dec (
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       char_done,
   input  wire logic       resync,
   input  wire logic [9:0] code,
   output logic            valid,
   output logic      [7:0] byte_out,
   output logic            kind,
   output logic            code_viol,
   output logic            disp_err,
   output logic            rd
);
   logic       rd_r;
   logic       free_r;
   logic       hit_cur;
   logic       hit_oth;
   logic [7:0] b_hit;
   logic       k_hit;
   logic       valid_r;
   logic [7:0] byte_r;
   logic       kind_r;
   logic       viol_r;
   logic       derr_r;

   // Table lookup in both columns
   always_comb begin
      hit_cur = 1'b0;
      hit_oth = 1'b0;
      b_hit   = 8'h00;
      k_hit   = 1'b0;
      for (int i = 0; i < 256; i++) begin
         if (erd_pkg::encode(8'(i), 1'b0, rd_r) == code) begin     // RQ19
            hit_cur = 1'b1;
            b_hit   = 8'(i);
         end else if (erd_pkg::encode(8'(i), 1'b0, ~rd_r) == code) begin
            hit_oth = 1'b1;
            b_hit   = 8'(i);
         end
      end
      foreach (erd_pkg::K_COMMA[j]) begin
         if (j < 2) begin
            logic [7:0] kb;
            kb = (j == 0) ? erd_pkg::K_COMMA : erd_pkg::K_SECOND;
            if (erd_pkg::encode(kb, 1'b1, rd_r) == code) begin     // RQ6
               hit_cur = 1'b1;
               b_hit   = kb;
               k_hit   = 1'b1;
            end else if (erd_pkg::encode(kb, 1'b1, ~rd_r) == code) begin
               hit_oth = 1'b1;
               b_hit   = kb;
               k_hit   = 1'b1;
            end
         end
      end
   end

   // Receiver disparity, free start after reset or resync
   always_ff @(posedge clock) begin
      if (!rst_n || resync) begin
         rd_r   <= erd_pkg::RD_RESET;
         free_r <= 1'b1;     // RQ10
      end else if (char_done) begin
         free_r <= 1'b0;
         rd_r   <= erd_pkg::char_rd(code, (!hit_cur && hit_oth) ? ~rd_r : rd_r);     // RQ11
      end
   end

   // One result per character
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         valid_r <= 1'b0;
         byte_r  <= 8'h00;
         kind_r  <= 1'b0;
         viol_r  <= 1'b0;
         derr_r  <= 1'b0;
      end else begin
         valid_r <= char_done & ~resync;     // RQ20
         if (char_done) begin
            byte_r <= b_hit;     // RQ2
            kind_r <= k_hit;
            viol_r <= ~hit_cur & ~hit_oth;     // RQ7
            derr_r <= ~hit_cur & hit_oth & ~free_r;     // RQ11
         end
      end
   end

   assign valid     = valid_r;
   assign byte_out  = byte_r;
   assign kind      = kind_r;
   assign code_viol = viol_r;
   assign disp_err  = derr_r;
   assign rd        = rd_r;
endmodule : erd_dec

// ---- erd_top.sv ----
// What this block does
// RQ1 - Each byte plus kind becomes one 10-bit character, sent bit by bit.
// RQ2 - Receiver gathers ten serial bits, decodes byte and kind.
// RQ3 - Byte bits 7..0 are HGFEDCBA; character order is abcdei fghj.
// RQ4 - A byte without a given kind is encoded as data.
// RQ5 - Characters are named by kind, EDCBA value and HGF value.
// RQ6 - All 256 data bytes and two control codes are supported.
// RQ7 - Any received pattern outside the used codes is a code violation.
// RQ8 - EDCBA with disparity gives abcdei; HGF with resulting disparity gives fghj.
// RQ9 - Transmit disparity is one bit, recomputed after every character.
// RQ10 - After reset or resync the receiver accepts either starting disparity.
// RQ11 - Receiver checks each character for its disparity, then updates disparity.
// RQ12 - Disparity chains from previous character through six-bit to four-bit.
// RQ13 - Sub-block ends positive with more ones, or 000111 or 0011.
// RQ14 - Sub-block ends negative with more zeros, or 111000 or 1100.
// RQ15 - Balanced sub-blocks keep the starting disparity.
// RQ16 - 000111 and 0011 only from positive; 111000 and 1100 from negative.
// RQ17 - Unbalanced sub-blocks alternate in polarity.
// RQ18 - HGF 111 uses alternate code for positive with e=i=0 or negative with e=i=1.
// RQ19 - One shared table drives encoding and receive checking.
// RQ20 - Decoder reports byte, kind, violation and disparity error per character.
`timescale 1ns/1ps
module erd_top (
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       tx_valid,
   output logic            tx_ready,
   input  wire logic [7:0] tx_byte,
   input  wire logic       tx_kind,
   input  wire logic       tx_kind_given,
   output logic            tx_serial,
   output logic            tx_rd,
   input  wire logic       rx_serial,
   input  wire logic       rx_resync,
   output logic            rx_valid,
   output logic      [7:0] rx_byte,
   output logic            rx_kind,
   output logic            rx_code_viol,
   output logic            rx_disp_err,
   output logic            rx_rd
);

   logic       tx_accept;
   logic [9:0] enc_code;
   logic [9:0] tx_sh_r;
   logic [3:0] tx_cnt_r;
   logic       tx_busy_r;
   logic       rx_s1_r;
   logic       rx_s2_r;
   logic [8:0] rx_sh_r;
   logic [3:0] rx_cnt_r;
   logic       rx_done;
   logic [9:0] rx_char;

   // Transmit side

   assign tx_ready  = !tx_busy_r || tx_cnt_r == erd_pkg::LAST_BIT;
   assign tx_accept = tx_valid && tx_ready;

   erd_enc u_enc (
      .clock      (clock),
      .rst_n      (rst_n),
      .load       (tx_accept),
      .byte_in    (tx_byte),     // RQ3
      .kind       (tx_kind),
      .kind_given (tx_kind_given),
      .code       (enc_code),
      .rd         (tx_rd)
   );

   // Load character, shift out a first
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         tx_sh_r <= 10'h000;
      end else if (tx_accept) begin
         tx_sh_r <= enc_code;     // RQ1
      end else begin
         tx_sh_r <= {tx_sh_r[8:0], 1'b0};     // RQ3
      end
   end

   // Bit counter
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         tx_cnt_r  <= 4'h0;
         tx_busy_r <= 1'b0;
      end else if (tx_accept) begin
         tx_cnt_r  <= 4'h0;
         tx_busy_r <= 1'b1;
      end else if (tx_busy_r) begin
         if (tx_cnt_r == erd_pkg::LAST_BIT)
            tx_busy_r <= 1'b0;
         else
            tx_cnt_r <= tx_cnt_r + 4'h1;
      end
   end

   assign tx_serial = tx_sh_r[9];

   // Receive side

   // Pin synchroniser
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rx_s1_r <= 1'b0;
         rx_s2_r <= 1'b0;
      end else begin
         rx_s1_r <= rx_serial;
         rx_s2_r <= rx_s1_r;
      end
   end

   // Gather ten bits
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rx_sh_r <= 9'h000;
      end else begin
         rx_sh_r <= {rx_sh_r[7:0], rx_s2_r};     // RQ2
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n || rx_resync)
         rx_cnt_r <= 4'h0;
      else if (rx_cnt_r == erd_pkg::LAST_BIT)
         rx_cnt_r <= 4'h0;
      else
         rx_cnt_r <= rx_cnt_r + 4'h1;
   end

   assign rx_done = rx_cnt_r == erd_pkg::LAST_BIT && !rx_resync;
   assign rx_char = {rx_sh_r, rx_s2_r};

   erd_dec u_dec (
      .clock     (clock),
      .rst_n     (rst_n),
      .char_done (rx_done),
      .resync    (rx_resync),
      .code      (rx_char),
      .valid     (rx_valid),
      .byte_out  (rx_byte),
      .kind      (rx_kind),
      .code_viol (rx_code_viol),
      .disp_err  (rx_disp_err),
      .rd        (rx_rd)
   );

   // Checks

   sequence s_tx_bits_out;
      ##1 tx_serial == $past(enc_code[9]) ##1 tx_serial == $past(enc_code[8], 2)
      ##8 tx_serial == $past(enc_code[0], 10);
   endsequence

   sequence s_tx_quiet;
      ##1 !tx_ready [*8];
   endsequence

   a_tx_bit_order: assert property (     // RQ1
      @(posedge clock) disable iff (!rst_n)
      tx_accept |-> s_tx_bits_out)
      else $error("serial bit order wrong");

   a_tx_char_spacing: assert property (     // RQ1
      @(posedge clock) disable iff (!rst_n)
      tx_accept |-> s_tx_quiet)
      else $error("character accepted before ten bits sent");

   a_tx_rd_update: assert property (     // RQ9
      @(posedge clock) disable iff (!rst_n)
      tx_accept |=> tx_rd == erd_pkg::char_rd($past(enc_code), $past(tx_rd)))
      else $error("transmit disparity not updated");

   a_tx_rd_hold: assert property (     // RQ9
      @(posedge clock) disable iff (!rst_n)
      !tx_accept |=> $stable(tx_rd))
      else $error("transmit disparity moved without a character");

   a_kind_default: assert property (     // RQ4
      @(posedge clock) disable iff (!rst_n)
      tx_accept && !tx_kind_given && tx_byte == erd_pkg::K_COMMA
      |=> tx_sh_r[9:4] != erd_pkg::K28_6B_NEG && tx_sh_r[9:4] != ~erd_pkg::K28_6B_NEG)
      else $error("byte without kind encoded as control");

   a_special_pos: assert property (     // RQ16
      @(posedge clock) disable iff (!rst_n)
      tx_accept && enc_code[9:4] == erd_pkg::SB6_POS_SPEC |-> tx_rd == erd_pkg::RD_POS)
      else $error("000111 sent from negative disparity");

   a_special_neg: assert property (     // RQ16
      @(posedge clock) disable iff (!rst_n)
      tx_accept && enc_code[9:4] == erd_pkg::SB6_NEG_SPEC |-> tx_rd == erd_pkg::RD_NEG)
      else $error("111000 sent from positive disparity");

   a_char_balance: assert property (     // RQ17
      @(posedge clock) disable iff (!rst_n)
      tx_accept |-> ($countones(enc_code) == 5) ||
                    ($countones(enc_code) == 6 && tx_rd == erd_pkg::RD_NEG) ||
                    ($countones(enc_code) == 4 && tx_rd == erd_pkg::RD_POS))
      else $error("character disparity not alternating");

   a_neutral_keep: assert property (     // RQ15
      @(posedge clock) disable iff (!rst_n)
      tx_accept && $countones(enc_code[9:4]) == 3 && $countones(enc_code[3:0]) == 2 &&
      enc_code[9:4] != erd_pkg::SB6_POS_SPEC && enc_code[9:4] != erd_pkg::SB6_NEG_SPEC &&
      enc_code[3:0] != erd_pkg::SB4_POS_SPEC && enc_code[3:0] != erd_pkg::SB4_NEG_SPEC
      |=> $stable(tx_rd))
      else $error("neutral character changed disparity");

   a_alt_seven: assert property (     // RQ18
      @(posedge clock) disable iff (!rst_n)
      tx_accept && !(tx_kind_given && tx_kind) && tx_byte[7:5] == erd_pkg::HGF_SEVEN &&
      enc_code[5:4] == 2'h0 && enc_code[9:4] != erd_pkg::SB6_POS_SPEC &&
      erd_pkg::sub_rd6(enc_code[9:4], tx_rd) == erd_pkg::RD_POS
      |-> enc_code[3:0] == ~erd_pkg::ALT7_NEG)
      else $error("alternate seven code not used");

   a_rx_result: assert property (     // RQ20
      @(posedge clock) disable iff (!rst_n)
      rx_done |=> rx_valid ##1 !rx_valid [*8])
      else $error("receive result not one pulse per character");

   a_rx_flags: assert property (     // RQ7
      @(posedge clock) disable iff (!rst_n)
      rx_valid |-> !(rx_code_viol && rx_disp_err))
      else $error("violation and disparity error together");

   a_rx_resync_free: assert property (     // RQ10
      @(posedge clock) disable iff (!rst_n)
      rx_resync ##1 (!rx_resync && !rx_done) [*8] ##2 rx_done |=> !rx_disp_err)
      else $error("disparity error on first character after resync");

endmodule : erd_top

// ---- erd_far_end.sv ----
`timescale 1ns/1ps
module erd_far_end (
   input  wire logic clock,
   output logic      rx_serial,
   output logic      rx_resync
);
   logic [9:0] q [$];
   logic [9:0] cur;
   int         bit_i = -1;
   int         res_cnt = 0;

   initial begin
      rx_serial = 1'b0;
      rx_resync = 1'b0;
   end

   task automatic push(input logic [9:0] ch);
      q.push_back(ch);
   endtask : push

   task automatic start(input int n);
      res_cnt = n;
   endtask : start

   // Resync pulse; first bit leads its end by the two synchroniser stages
   always @(negedge clock) begin
      rx_resync <= (res_cnt > 0);
      if (res_cnt > 0)
         res_cnt = res_cnt - 1;
      if (res_cnt < 2 && bit_i < 0 && q.size() > 0) begin
         cur = q.pop_front();
         bit_i = 9;
      end
      if (res_cnt < 2 && bit_i >= 0) begin
         rx_serial <= cur[bit_i];
         bit_i = bit_i - 1;
      end else begin
         rx_serial <= ~rx_serial;
      end
   end
endmodule : erd_far_end

// ---- erd_top_bench.sv ----
`timescale 1ns/1ps
module erd_top_bench;
   typedef struct packed {logic [9:0] ch; logic rd;} erd_txe_t;
   typedef struct packed {logic [7:0] b; logic k; logic v; logic d; logic rd;} erd_rxe_t;
   localparam logic [5:0] SIX_NEG [32] = '{6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19,
      6'h38, 6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17, 6'h1b, 6'h23, 6'h13,
      6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a, 6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
   localparam logic [3:0] FOUR_NEG [8] = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
   logic       clock, rst_n, tx_valid, tx_ready, tx_kind, tx_kind_given, tx_serial, tx_rd;
   logic [7:0] tx_byte, rx_byte;
   logic       rx_serial, rx_resync, rx_valid, rx_kind, rx_code_viol, rx_disp_err, rx_rd;
   logic       model_rd, acc, rd;
   logic [9:0] got;
   logic [10:0] e;
   int         n_errors = 0;
   int         num_checks = 0;
   int         left = 0;
   erd_txe_t   txq [$];
   erd_txe_t   tx_e;
   erd_rxe_t   rxq [$];
   erd_rxe_t   pend [$];
   erd_rxe_t   rx_e;

   erd_top uut (.clock, .rst_n, .tx_valid, .tx_ready, .tx_byte, .tx_kind, .tx_kind_given,
      .tx_serial, .tx_rd, .rx_serial, .rx_resync, .rx_valid, .rx_byte, .rx_kind,
      .rx_code_viol, .rx_disp_err, .rx_rd);
   erd_far_end far (.clock, .rx_serial, .rx_resync);

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string what);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %s got %h want %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : conclude

   // Reference coder: returns ending disparity above the character
   function automatic logic [10:0] ref_enc(input logic [7:0] b, input logic k, input logic r);
      logic [5:0] s6;
      logic [3:0] s4;
      logic       r6;
      s6 = k ? 6'h0f : SIX_NEG[b[4:0]];
      if (r && ($countones(s6) != 3 || s6 == 6'h38)) s6 = ~s6;
      r6 = (s6 == 6'h07) || ($countones(s6) > 3) || ($countones(s6) == 3 && s6 != 6'h38 && r);
      if (!k && b[7:5] == 3'h7 && (r6 ? s6[1:0] == 2'h0 : s6[1:0] == 2'h3)) begin
         s4 = r6 ? 4'h8 : 4'h7;
      end else begin
         s4 = FOUR_NEG[b[7:5]];
         if (r6 && ($countones(s4) != 2 || s4 == 4'hc)) s4 = ~s4;
      end
      return {(s4 == 4'h3) || ($countones(s4) > 2) || ($countones(s4) == 2 && s4 != 4'hc && r6),
              s6, s4};
   endfunction : ref_enc

   task automatic tx_send(input logic [7:0] b, input logic k, input logic g);
      logic [10:0] x;
      int          n;
      @(negedge clock);
      tx_valid = 1'b1;
      tx_byte = b;
      tx_kind = k;
      tx_kind_given = g;
      n = 0;
      while (tx_ready !== 1'b1 && n < 20) begin
         @(negedge clock);
         n++;
      end
      x = ref_enc(b, k & g, model_rd);
      model_rd = x[10];
      txq.push_back('{x[9:0], x[10]});
      @(posedge clock);
   endtask : tx_send

   task automatic rx_char(input logic [9:0] ch, input erd_rxe_t x);
      far.push(ch);
      pend.push_back(x);
   endtask : rx_char

   task automatic drain();
      int n;
      n = 0;
      while ((rxq.size() > 0 || txq.size() > 0 || left > 0) && n < 600) begin
         @(posedge clock);
         n++;
      end
   endtask : drain

   always @(posedge clock) acc <= rst_n && tx_valid && tx_ready;

   // Serial output gathered after each accept
   always @(negedge clock) begin
      if (acc) begin
         left = 10;
         tx_e = txq.pop_front();
         check(12'(tx_rd), 12'(tx_e.rd), "tx_rd");
      end
      if (left > 0) begin
         check(12'(tx_ready), 12'(left == 1), "tx_ready");
         got = {got[8:0], tx_serial};
         left--;
         if (left == 0) check(12'(got), 12'(tx_e.ch), "tx char");
      end
   end

   always @(negedge clock) begin
      if (rx_valid === 1'b1 && rxq.size() > 0) begin
         rx_e = rxq.pop_front();
         check({rx_byte, rx_e.v ? 1'b0 : rx_kind, rx_code_viol, rx_disp_err, rx_rd}, rx_e,
               "rx");
      end
   end

   initial begin
      #2000000;
      n_errors++;
      conclude();
   end

   initial begin
      rst_n = 1'b0;
      tx_valid = 1'b0;
      tx_byte = 8'h00;
      tx_kind = 1'b0;
      tx_kind_given = 1'b0;
      model_rd = erd_pkg::RD_RESET;
      void'($urandom(32'h8cfe6472));
      repeat (6) @(negedge clock);
      check({tx_serial, tx_rd, tx_ready, rx_valid}, 12'h002, "reset");
      rst_n = 1'b1;
      // Control codes, alternate seven after positive, missing kind
      tx_send(erd_pkg::K_COMMA, 1'b1, 1'b1);
      tx_send(8'heb, 1'b0, 1'b1);
      tx_send(erd_pkg::K_SECOND, 1'b1, 1'b1);
      for (int i = 0; i < 256; i++) tx_send(8'(i), 1'b0, 1'b1);
      for (int i = 0; i < 32; i++) tx_send(8'($urandom), 1'($urandom), 1'b0);
      @(negedge clock);
      tx_valid = 1'b0;
      drain();
      $display("tx test done");
      for (int p = 1; p >= 0; p--) begin
         @(posedge clock);
         far.start(4);
         rd = 1'(p);
         for (int i = 0; i < 12; i++) begin
            tx_byte = (i == 0) ? 8'h00 : 8'($urandom);
            e = ref_enc(tx_byte, 1'b0, rd);
            rx_char(e[9:0], '{tx_byte, 1'b0, 1'b0, 1'b0, e[10]});
            rd = e[10];
         end
         e = ref_enc(erd_pkg::K_COMMA, 1'b1, rd);
         rx_char(e[9:0], '{erd_pkg::K_COMMA, 1'b1, 1'b0, 1'b0, e[10]});
         e = ref_enc(erd_pkg::K_SECOND, 1'b1, e[10]);
         rx_char(e[9:0], '{erd_pkg::K_SECOND, 1'b1, 1'b0, 1'b0, e[10]});
         e = ref_enc(8'h00, 1'b0, ~e[10]);
         rx_char(e[9:0], '{8'h00, 1'b0, 1'b0, 1'b1, e[10]});
         rx_char(10'h000, '{8'h00, 1'b0, 1'b1, 1'b0, erd_pkg::RD_NEG});
         repeat (3) @(posedge clock);
         while (pend.size() > 0) rxq.push_back(pend.pop_front());
         drain();
         $display("rx burst done");
      end
      conclude();
   end
endmodule : erd_top_bench
